// ==== design/timer_option_pkg.sv ====
// Constants for the timer option configuration register
//
// Contract
// R1 - Configuration register at 0x81, fully readable and writable by software.
// R2 - Bit 7 set disables all second port pull-ups; clear follows port latches.
// R3 - Bit 6 picks external interrupt edge: set rising, clear falling.
// R4 - Bit 5 picks timer clock: set external pin, clear instruction clock.
// R5 - Bit 4 picks external pin edge: set falling, clear rising.
// R6 - Bit 3 is prescaler assignment; bits 2..0 are the rate field.
// R7 - Assignment set gives the timer an undivided 1:1 rate.
// R8 - Assignment set gives prescaler to watchdog, clear to the timer.
// R9 - Rate field selects power-of-two division: timer 2..256, watchdog 1..128.
// R10 - Writes act from the next cycle; reads return all eight stored bits. Decoded controls here change two cycles after the write strobe.
package timer_option_pkg;
    localparam logic [7:0] OPT_ADDR       = 8'h81;
    localparam logic [7:0] OPT_RESET      = 8'hff;
    localparam int         BIT_PULLUP_DIS = 7;
    localparam int         BIT_INT_EDGE   = 6;
    localparam int         BIT_CLK_SRC    = 5;
    localparam int         BIT_SRC_EDGE   = 4;
    localparam int         BIT_PSC_ASSIGN = 3;
    localparam int         RATE_MSB       = 2;
    localparam int         RATE_LSB       = 0;
endpackage

// ==== design/timer_option_config.sv ====
// Timer option configuration register and its decoded controls
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module timer_option_config
    import timer_option_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       SYS_RST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    output logic      [7:0] OPT_VALUE,
    output logic            WEAK_PULLUP_DISABLE,
    output logic            EXT_INT_EDGE_SELECT,
    output logic            TIMER_CLOCK_SOURCE_SELECT,
    output logic            TIMER_SOURCE_EDGE_SELECT,
    output logic            PRESCALER_ASSIGN,
    output logic      [2:0] PRESCALER_RATE_FIELD,
    output logic      [8:0] TIMER_DIVIDE,
    output logic      [7:0] WATCHDOG_DIVIDE
);
    logic [7:0] opt_r;
    logic [7:0] opt_nxt;

    // Address decode shared by the write and read paths
    function automatic logic opt_selected(input logic [7:0] a);
        if (a == OPT_ADDR) begin
            opt_selected = 1'b1;
        end else begin
            opt_selected = 1'b0;
        end
    endfunction

    // Timer ratio: undivided while the watchdog owns the prescaler
    function automatic logic [8:0] timer_ratio(input logic [7:0] cfg);
        logic [3:0] shift;
        shift = {1'b0, cfg[RATE_MSB:RATE_LSB]} + 4'h1;
        if (cfg[BIT_PSC_ASSIGN]) begin
            timer_ratio = 9'h001;
        end else begin
            timer_ratio = 9'h001 << shift;
        end
    endfunction

    // Watchdog ratio: undivided while the timer owns the prescaler
    function automatic logic [7:0] watchdog_ratio(input logic [7:0] cfg);
        if (cfg[BIT_PSC_ASSIGN]) begin
            watchdog_ratio = 8'h01 << cfg[RATE_MSB:RATE_LSB];
        end else begin
            watchdog_ratio = 8'h01;
        end
    endfunction

    always_comb begin
        opt_nxt = opt_r;
        if (WR && opt_selected(ADDR)) begin
            opt_nxt = WDATA; // see R1
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            opt_r <= OPT_RESET;
        end else begin
            opt_r <= opt_nxt;
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RDATA <= 8'h00;
        end else if (RD && opt_selected(ADDR)) begin
            RDATA <= opt_r; // see R10
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Decoded controls follow the register one cycle after it changes
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            OPT_VALUE <= OPT_RESET;
        end else begin
            OPT_VALUE <= opt_r; // see R10
        end
    end

    // Pull-up disable for the second port
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            WEAK_PULLUP_DISABLE <= OPT_RESET[BIT_PULLUP_DIS];
        end else begin
            WEAK_PULLUP_DISABLE <= opt_r[BIT_PULLUP_DIS]; // see R2
        end
    end

    // Edge selects for the interrupt pin and the external clock pin
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            EXT_INT_EDGE_SELECT      <= OPT_RESET[BIT_INT_EDGE];
            TIMER_SOURCE_EDGE_SELECT <= OPT_RESET[BIT_SRC_EDGE];
        end else begin
            EXT_INT_EDGE_SELECT      <= opt_r[BIT_INT_EDGE]; // see R3
            TIMER_SOURCE_EDGE_SELECT <= opt_r[BIT_SRC_EDGE]; // see R5
        end
    end

    // Timer clock source
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            TIMER_CLOCK_SOURCE_SELECT <= OPT_RESET[BIT_CLK_SRC];
        end else begin
            TIMER_CLOCK_SOURCE_SELECT <= opt_r[BIT_CLK_SRC]; // see R4
        end
    end

    // Prescaler assignment and rate field
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PRESCALER_ASSIGN     <= OPT_RESET[BIT_PSC_ASSIGN];
            PRESCALER_RATE_FIELD <= OPT_RESET[RATE_MSB:RATE_LSB];
        end else begin
            PRESCALER_ASSIGN     <= opt_r[BIT_PSC_ASSIGN]; // see R6
            PRESCALER_RATE_FIELD <= opt_r[RATE_MSB:RATE_LSB]; // see R6
        end
    end

    // Division ratios seen by the timer and the watchdog
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            TIMER_DIVIDE    <= timer_ratio(OPT_RESET);
            WATCHDOG_DIVIDE <= watchdog_ratio(OPT_RESET);
        end else begin
            TIMER_DIVIDE    <= timer_ratio(opt_r); // see R7 R9
            WATCHDOG_DIVIDE <= watchdog_ratio(opt_r); // see R8 R9
        end
    end

    AST_WRITE_STORED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R1
        (WR && ADDR == OPT_ADDR) |=> opt_r == $past(WDATA))
        else $error("Write to config register not stored");

    AST_READ_BACK: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R10
        (RD && ADDR == OPT_ADDR) |=> RDATA == $past(opt_r))
        else $error("Read data differ from stored value");

    AST_UNMAPPED_ZERO: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R1
        (RD && ADDR != OPT_ADDR) |=> RDATA == 8'h00)
        else $error("Unmapped read not zero");

    sequence s_write_cfg;
        WR && ADDR == OPT_ADDR;
    endsequence

    AST_OUTPUT_LATENCY: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R10
        s_write_cfg ##2 !$past(SYS_RST) |-> OPT_VALUE == $past(WDATA, 2))
        else $error("Controls did not follow write in two cycles");

    AST_PULLUP: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R2
        ##1 WEAK_PULLUP_DISABLE == $past(opt_r[BIT_PULLUP_DIS]))
        else $error("Pull-up disable wrong");

    AST_EDGES: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R3
        ##1 (EXT_INT_EDGE_SELECT == $past(opt_r[BIT_INT_EDGE])
             && TIMER_SOURCE_EDGE_SELECT == $past(opt_r[BIT_SRC_EDGE])))
        else $error("Edge selects wrong");

    AST_CLK_SRC: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R4
        ##1 TIMER_CLOCK_SOURCE_SELECT == $past(opt_r[BIT_CLK_SRC]))
        else $error("Clock source wrong");

    AST_TIMER_UNDIVIDED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R7
        PRESCALER_ASSIGN |-> TIMER_DIVIDE == 9'h001)
        else $error("Timer prescaled while prescaler on watchdog");

    AST_RATE_TIMER: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R9
        !PRESCALER_ASSIGN |-> TIMER_DIVIDE == (9'h002 << PRESCALER_RATE_FIELD)
                              && WATCHDOG_DIVIDE == 8'h01)
        else $error("Timer division wrong");

    AST_RATE_WDOG: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R8
        PRESCALER_ASSIGN |-> WATCHDOG_DIVIDE == (8'h01 << PRESCALER_RATE_FIELD))
        else $error("Watchdog division wrong");

    sequence s_no_cfg_write;
        !(WR && ADDR == OPT_ADDR);
    endsequence

    sequence s_write_timer_owner;
        s_write_cfg ##0 !WDATA[BIT_PSC_ASSIGN];
    endsequence

    sequence s_write_watchdog_owner;
        s_write_cfg ##0 WDATA[BIT_PSC_ASSIGN];
    endsequence

    AST_HOLD_NO_WRITE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R1
        s_no_cfg_write |=> $stable(opt_r))
        else $error("Config register changed without a write");

    AST_UNMAPPED_WRITE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R1
        (WR && ADDR != OPT_ADDR) |=> $stable(opt_r))
        else $error("Unmapped write changed the config register");

    AST_RDATA_IDLE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R10
        !RD |=> RDATA == 8'h00)
        else $error("Read data not cleared outside a read");

    AST_FIELDS_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R2 R3 R4 R5 R6
        s_write_cfg |-> ##2 {WEAK_PULLUP_DISABLE, EXT_INT_EDGE_SELECT, TIMER_CLOCK_SOURCE_SELECT,
            TIMER_SOURCE_EDGE_SELECT, PRESCALER_ASSIGN, PRESCALER_RATE_FIELD} == $past(WDATA, 2))
        else $error("Field controls did not follow the written value");

    AST_TIMER_RATIO_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R8
        s_write_timer_owner |-> ##2 TIMER_DIVIDE == (9'h002 << $past(WDATA[RATE_MSB:RATE_LSB], 2)))
        else $error("Timer ratio did not follow the written rate");

    AST_WDOG_RATIO_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see R7
        s_write_watchdog_owner |-> ##2 (TIMER_DIVIDE == 9'h001
            && WATCHDOG_DIVIDE == (8'h01 << $past(WDATA[RATE_MSB:RATE_LSB], 2))))
        else $error("Watchdog ratio did not follow the written rate");

    AST_RESET_VALUE: assert property (@(posedge CLK_SYS) // see R10
        SYS_RST |=> opt_r == OPT_RESET && OPT_VALUE == OPT_RESET)
        else $error("Reset did not restore the configuration");
endmodule

// ==== verification/timer_option_config_tb.sv ====
// Self-checking bench for the timer option configuration register
`timescale 1ns/1ns
module timer_option_config_tb;
    import timer_option_pkg::*;
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata, opt_value, wd_div, d;
    wire  [7:0] ctl;
    logic [8:0] tm_div;
    int         mismatches = 0;
    int         total_checks = 0;
    int         cycles = 0;
    timer_option_config dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .OPT_VALUE(opt_value), .WEAK_PULLUP_DISABLE(ctl[7]), .EXT_INT_EDGE_SELECT(ctl[6]),
        .TIMER_CLOCK_SOURCE_SELECT(ctl[5]), .TIMER_SOURCE_EDGE_SELECT(ctl[4]), .PRESCALER_ASSIGN(ctl[3]),
        .PRESCALER_RATE_FIELD(ctl[2:0]), .TIMER_DIVIDE(tm_div), .WATCHDOG_DIVIDE(wd_div));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard, run needs about 90 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 check({1'b0, rdata}, {1'b0, exp}, "read data");
    endtask
    // Write then read with no gap between the strobes
    task automatic write_read(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 check({1'b0, rdata}, {1'b0, v}, "read after write");
    endtask
    // Decoded outputs, one cycle behind the stored value
    task automatic check_outputs(input logic [7:0] v);
        check({1'b0, opt_value}, {1'b0, v}, "copy");
        check({1'b0, ctl}, {1'b0, v}, "fields");
        check(tm_div, v[3] ? 9'h001 : 9'h002 << v[2:0], "timer ratio");
        check({1'b0, wd_div}, v[3] ? 9'h001 << v[2:0] : 9'h001, "watchdog ratio");
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        read_reg(OPT_ADDR, OPT_RESET);
        check_outputs(OPT_RESET);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            d = {i[3:0], i[3:0]};
            write_reg(OPT_ADDR, d);
            read_reg(OPT_ADDR, d);
            check_outputs(d);
        end
        $display("field and ratio test done");
        write_reg(8'h01, 8'h00);
        write_reg(8'h80, 8'h00);
        read_reg(8'h80, 8'h00);
        read_reg(OPT_ADDR, d);
        check_outputs(d);
        $display("unmapped address test done");
        write_read(OPT_ADDR, 8'h5a);
        check_outputs(8'h5a);
        $display("back-to-back test done");
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        read_reg(OPT_ADDR, OPT_RESET);
        check_outputs(OPT_RESET);
        $display("mid-run reset test done");
        final_report();
    end
endmodule
